// File: dv/diverse_trip_voting_logic_test.sv
// Self-checking bench for the diverse trip voting logic.
`timescale 1ns/1ps
`include "dps_map.svh"
module diverse_trip_voting_logic_test;
   localparam int unsigned PERSIST = 20;
   // Each entry: parameters tripped, run mode, expected isolation and scram outputs.
   localparam logic [24:0] ISO [13] = '{{15'h0080, 1'b0, 9'h000}, {15'h0080, 1'b1, 9'h100},
      {15'h0100, 1'b1, 9'h100}, {15'h0200, 1'b1, 9'h102}, {15'h0200, 1'b0, 9'h002},
      {15'h0020, 1'b0, 9'h003}, {15'h0400, 1'b0, 9'h080}, {15'h0800, 1'b0, 9'h080},
      {15'h1000, 1'b0, 9'h040}, {15'h2000, 1'b0, 9'h000}, {15'h2008, 1'b0, 9'h031},
      {15'h0002, 1'b0, 9'h009}, {15'h4000, 1'b0, 9'h004}};
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic run_mode = 1'b0;
   logic [59:0] sens_cmd = '0;
   logic [4:0] man_cmd = '0;
   wire logic [59:0] sens;
   wire logic [4:0] man;
   logic [2:0] proc_scram_q;
   logic [1:0] emergency_core_cooling_drv_start_q;
   logic [`DPS_NUM_SRV-1:0] srv_solenoid_q;
   logic [`DPS_NUM_DPV-1:0] dpv_squib_q;
   logic [`DPS_NUM_GRAVITY_CORE_COOLING-1:0] gravity_core_cooling_squib_q;
   logic [`DPS_NUM_SLC_LOOP-1:0] slc_squib_q;
   logic scram_return_open_q, emergency_core_cooling_actuate_q, ic_initiate_q, pool_equalize_q, main_steam_isolation_valves_close_q;
   logic ic_isol_close_q, cleanup_isol_close_q, fw_breaker_trip_q, fw_cont_isol_close_q;
   logic fw_runback_q, fw_pump_trip_q;
   int err_total = 0;
   int tests_run = 0;
   int cyc_count = 0;

   plant_model plant_u (.sens_cmd(sens_cmd), .man_cmd(man_cmd), .sens(sens), .man(man));

   diverse_trip_voting_logic #(.EMERGENCY_CORE_COOLING_PERSIST_CYC(PERSIST)) dut_u (.clk(clk), .arst_n(arst_n),
      .vessel_press_high(sens[3:0]), .level_eight_high(sens[7:4]), .level_three_low(sens[11:8]),
      .drywell_press_high(sens[15:12]), .pool_temp_high(sens[19:16]), .main_steam_isolation_valves_closed(sens[23:20]),
      .level_one_low(sens[27:24]), .steam_flow_high(sens[31:28]), .vessel_press_low(sens[35:32]),
      .level_two_low(sens[39:36]), .ic_steam_flow_high(sens[43:40]),
      .ic_cond_flow_high(sens[47:44]), .cleanup_dflow_high(sens[51:48]),
      .fw_dp_high(sens[55:52]), .level_nine_high(sens[59:56]), .run_mode(run_mode),
      .man_scram_sw(man[0]), .man_scram_odu(man[1]), .man_emergency_core_cooling_sw(man[2]),
      .man_emergency_core_cooling_odu(man[3]), .man_pool_equalize(man[4]), .proc_scram_q(proc_scram_q),
      .scram_return_open_q(scram_return_open_q), .emergency_core_cooling_drv_start_q(emergency_core_cooling_drv_start_q),
      .emergency_core_cooling_actuate_q(emergency_core_cooling_actuate_q), .srv_solenoid_q(srv_solenoid_q),
      .dpv_squib_q(dpv_squib_q), .gravity_core_cooling_squib_q(gravity_core_cooling_squib_q), .slc_squib_q(slc_squib_q),
      .ic_initiate_q(ic_initiate_q), .pool_equalize_q(pool_equalize_q),
      .main_steam_isolation_valves_close_q(main_steam_isolation_valves_close_q), .ic_isol_close_q(ic_isol_close_q),
      .cleanup_isol_close_q(cleanup_isol_close_q), .fw_breaker_trip_q(fw_breaker_trip_q),
      .fw_cont_isol_close_q(fw_cont_isol_close_q), .fw_runback_q(fw_runback_q),
      .fw_pump_trip_q(fw_pump_trip_q));

   always #4 clk = ~clk;

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // The whole sequence needs well under a thousand cycles.
   always @(posedge clk)
   begin
      cyc_count++;
      if (cyc_count == 3000)
      begin
         err_total++;
         wrap_up();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic do_reset();
      @(negedge clk);
      arst_n = 1'b0;
      sens_cmd = '0;
      man_cmd = '0;
      repeat (6) @(negedge clk);
      chk({proc_scram_q, scram_return_open_q, main_steam_isolation_valves_close_q, emergency_core_cooling_actuate_q}, 16'h0);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
   endtask

   task automatic t_scram();
      for (int p = 0; p < 6; p++)
      begin
         sens_cmd[4*p +: 4] = 4'h8;
         repeat (3) @(negedge clk);
         chk(scram_return_open_q, 16'h0);
         sens_cmd[4*p +: 4] = 4'h9;
         repeat (3) @(negedge clk);
         chk({proc_scram_q, scram_return_open_q}, 16'hf);
         sens_cmd = '0;
         repeat (3) @(negedge clk);
      end
      for (int s = 0; s < 2; s++)
      begin
         man_cmd[s] = 1'b1;
         @(negedge clk);
         chk({proc_scram_q, scram_return_open_q}, 16'h1);
         man_cmd = '0;
         repeat (2) @(negedge clk);
      end
      man_cmd[4] = 1'b1;
      @(negedge clk);
      chk(pool_equalize_q, 16'h1);
      man_cmd = '0;
      $display("test scram done");
   endtask

   task automatic t_iso();
      for (int i = 0; i < 13; i++)
      begin
         for (int p = 0; p < 15; p++)
            if (ISO[i][p + 10])
               sens_cmd[4*p +: 4] = 4'h6;
         run_mode = ISO[i][9];
         repeat (3) @(negedge clk);
         chk({main_steam_isolation_valves_close_q, ic_isol_close_q, cleanup_isol_close_q, fw_breaker_trip_q,
            fw_cont_isol_close_q, fw_runback_q, fw_pump_trip_q, ic_initiate_q,
            scram_return_open_q}, {7'h0, ISO[i][8:0]});
         sens_cmd = '0;
         repeat (3) @(negedge clk);
      end
      $display("test isolation done");
   endtask

   task automatic t_emergency_core_cooling();
      int n;
      sens_cmd[27:24] = 4'h3;
      repeat (PERSIST / 2) @(negedge clk);
      sens_cmd = '0;
      repeat (PERSIST + 10) @(negedge clk);
      chk(emergency_core_cooling_drv_start_q, 16'h0);
      sens_cmd[27:24] = 4'hc;
      // Voted level reaches the drivers after three edges, then must persist a full count.
      repeat (PERSIST + 3) @(negedge clk);
      chk(emergency_core_cooling_drv_start_q, 16'h0);
      n = 0;
      while (emergency_core_cooling_actuate_q !== 1'b1 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      chk(16'(n), 16'h1);
      sens_cmd = '0;
      repeat (4) @(negedge clk);
      chk({emergency_core_cooling_drv_start_q, emergency_core_cooling_actuate_q, ic_initiate_q}, 16'hf);
      chk({srv_solenoid_q, slc_squib_q}, 16'hfff);
      chk({dpv_squib_q, gravity_core_cooling_squib_q}, 16'hffff);
      for (int s = 2; s < 4; s++)
      begin
         do_reset();
         chk(emergency_core_cooling_drv_start_q, 16'h0);
         man_cmd[s] = 1'b1;
         @(negedge clk);
         man_cmd = '0;
         repeat (4) @(negedge clk);
         chk({emergency_core_cooling_drv_start_q, emergency_core_cooling_actuate_q}, 16'h7);
      end
      $display("test core cooling done");
   endtask

   initial
   begin
      do_reset();
      t_scram();
      t_iso();
      t_emergency_core_cooling();
      wrap_up();
   end
endmodule

// File: dv/dps_properties.sv
// Concurrent checks on the ports of the diverse trip voting logic.
`timescale 1ns/1ps
`include "dps_map.svh"
module dps_checker
(
   input wire logic clk, // System clock.
   input wire logic arst_n, // Asynchronous reset, active low.
   input wire logic [3:0] vessel_press_high, // Channel trips.
   input wire logic [3:0] level_eight_high, // Channel trips.
   input wire logic [3:0] level_three_low, // Channel trips.
   input wire logic [3:0] drywell_press_high, // Channel trips.
   input wire logic [3:0] pool_temp_high, // Channel trips.
   input wire logic [3:0] main_steam_isolation_valves_closed, // Channel trips.
   input wire logic [3:0] fw_dp_high, // Channel trips.
   input wire logic [3:0] level_nine_high, // Channel trips.
   input wire logic run_mode, // Run mode.
   input wire logic man_scram_sw, // Manual scram switch.
   input wire logic man_scram_odu, // Manual scram from display.
   input wire logic man_pool_equalize, // Manual pool equalization.
   input wire logic [2:0] proc_scram_q, // Processor scram decisions.
   input wire logic scram_return_open_q, // Voted scram.
   input wire logic [1:0] emergency_core_cooling_drv_start_q, // Driver seal-in.
   input wire logic emergency_core_cooling_actuate_q, // Core cooling actuation.
   input wire logic [`DPS_NUM_DPV-1:0] dpv_squib_q, // Depressurization squibs.
   input wire logic main_steam_isolation_valves_close_q, // Steam valve closure.
   input wire logic fw_breaker_trip_q, // Feedwater breaker trip.
   input wire logic fw_runback_q, // Feedwater runback.
   input wire logic fw_pump_trip_q, // Feedwater pump trip.
   input wire logic pool_equalize_q // Pool equalization.
);
   logic [2:0] cnt_q;
   wire rdy = cnt_q == 3'h5;
   wire scv = dps_pkg::two_of_four(vessel_press_high) | dps_pkg::two_of_four(level_eight_high)
      | dps_pkg::two_of_four(level_three_low) | dps_pkg::two_of_four(drywell_press_high)
      | dps_pkg::two_of_four(pool_temp_high) | dps_pkg::two_of_four(main_steam_isolation_valves_closed);
   wire l8v = dps_pkg::two_of_four(level_eight_high);
   wire l9v = dps_pkg::two_of_four(level_nine_high);
   wire fwv = dps_pkg::two_of_four(fw_dp_high) & dps_pkg::two_of_four(drywell_press_high);
   wire mscr = man_scram_sw | man_scram_odu;
   // History from before and just after reset is not trusted until this count saturates.
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
         cnt_q <= 3'h0;
      else if (!rdy)
         cnt_q <= cnt_q + 3'h1;
   a_scram_vote:
   assert property (@(posedge clk) disable iff (!arst_n)
      rdy |-> scram_return_open_q == ($past(scv, 3) | $past(mscr))) else $error("scram vote");
   a_proc_links:
   assert property (@(posedge clk) disable iff (!arst_n)
      rdy |-> proc_scram_q == {3{$past(scv, 3)}}) else $error("processor scram");
   a_runback_level:
   assert property (@(posedge clk) disable iff (!arst_n)
      rdy |-> fw_runback_q == $past(l8v, 3)) else $error("runback");
   a_pump_trip:
   assert property (@(posedge clk) disable iff (!arst_n)
      rdy |-> fw_pump_trip_q == $past(l9v, 3)) else $error("pump trip");
   a_fw_isolate:
   assert property (@(posedge clk) disable iff (!arst_n)
      rdy |-> fw_breaker_trip_q == $past(fwv, 3)) else $error("feedwater isolation");
   a_main_steam_isolation_valves_run:
   assert property (@(posedge clk) disable iff (!arst_n)
      (!run_mode) [*3] |-> !main_steam_isolation_valves_close_q) else $error("steam valves outside run");
   a_pool_manual:
   assert property (@(posedge clk) disable iff (!arst_n)
      rdy |-> pool_equalize_q == $past(man_pool_equalize)) else $error("pool equalize");
   a_seal_hold:
   assert property (@(posedge clk) disable iff (!arst_n)
      (|emergency_core_cooling_drv_start_q) |=> (emergency_core_cooling_drv_start_q & $past(emergency_core_cooling_drv_start_q)) ==
      $past(emergency_core_cooling_drv_start_q)) else $error("seal released");
   a_both_drivers:
   assert property (@(posedge clk) disable iff (!arst_n)
      emergency_core_cooling_actuate_q |-> emergency_core_cooling_drv_start_q == 2'h3) else $error("drivers disagree");
   a_dpv_paths:
   assert property (@(posedge clk) disable iff (!arst_n)
      (|dpv_squib_q) |-> dpv_squib_q == '1 && $past(emergency_core_cooling_actuate_q)) else $error("squib");
endmodule

bind diverse_trip_voting_logic dps_checker chk_u (.*);

// File: dv/plant_model.sv
// Plant side model: sensor channel trip levels and operator requests.
`timescale 1ns/1ps
module plant_model
(
   input wire logic [59:0] sens_cmd, // Requested channel trips, one nibble per parameter.
   input wire logic [4:0] man_cmd, // Requested operator actions.
   output logic [59:0] sens, // Channel trip levels toward the block.
   output logic [4:0] man // Switch and display requests toward the block.
);
   // Sensors are hardwired levels, so the model holds them with no delay of its own.
   assign sens = sens_cmd;
   // Switches and the display unit are separate sources of the same commands.
   assign man = man_cmd;
endmodule

// File: rtl/diverse_trip_voting_logic.sv
// Diverse scram, core cooling and isolation logic with triple processors and 2-of-3 voting.
`timescale 1ns/1ps
`include "dps_map.svh"

// Operation
// - Scram on vessel pressure, L8 high, L3 low, drywell, pool temperature, steam valves.
// - Three redundant processors each see the same four channels per parameter.
// - A processor trips a parameter when at least two of four channels trip.
// - Each processor output is separate; scram switches open on two of three.
// - Scram output is driven high to trip; low output means no trip.
// - Hardwired switch or display unit request each cause a manual scram.
// - Level one low starts gravity cooling, liquid injection, condenser and depressurization.
// - Suppression pool equalization starts only on manual request, never automatically.
// - Manual core cooling request comes from local inputs or the display unit.
// - Core cooling condition present ten seconds seals in and holds a start.
// - Automatic core cooling start needs a coincidence trip from two of three processors.
// - Two drivers evaluate the voted start; actuation needs both to agree.
// - One dedicated solenoid per relief valve; all group valves driven through it.
// - Depressurization squib fires only on three simultaneous path trips.
// - Gravity cooling squib fires only when both dual paths trip together.
// - Liquid injection squibs use dual simultaneous paths, one valve per loop.
// - Isolations use 2-of-4 channels, 2-of-3 processors, and drive high to actuate.
// - Steam valves close on steam flow, low pressure or L2, in Run only.
// - Condenser valves close on steam or condensate flow; cleanup on differential flow.
// - Feedwater line break with drywell pressure trips pump breakers, closes isolation.
// - Isolation condenser starts on level two low or steam valve closure.
// - Feedwater runback at level eight high; pump trip at level nine high.

module diverse_trip_voting_logic
#(
   parameter int unsigned EMERGENCY_CORE_COOLING_PERSIST_CYC = `DPS_EMERGENCY_CORE_COOLING_PERSIST_CYC
)
(
   input wire logic clk, // 125 MHz system clock.
   input wire logic arst_n, // Asynchronous reset, active low.
   input wire logic [3:0] vessel_press_high, // Channel trips, high vessel pressure.
   input wire logic [3:0] level_eight_high, // Channel trips, water level high.
   input wire logic [3:0] level_three_low, // Channel trips, water level low for scram.
   input wire logic [3:0] drywell_press_high, // Channel trips, high drywell pressure.
   input wire logic [3:0] pool_temp_high, // Channel trips, suppression pool temperature.
   input wire logic [3:0] main_steam_isolation_valves_closed, // Channel trips, steam isolation valves closed.
   input wire logic [3:0] level_one_low, // Channel trips, core cooling initiation level.
   input wire logic [3:0] steam_flow_high, // Channel trips, main steam flow high.
   input wire logic [3:0] vessel_press_low, // Channel trips, vessel pressure low.
   input wire logic [3:0] level_two_low, // Channel trips, water level low for isolation.
   input wire logic [3:0] ic_steam_flow_high, // Channel trips, condenser steam flow.
   input wire logic [3:0] ic_cond_flow_high, // Channel trips, condenser condensate flow.
   input wire logic [3:0] cleanup_dflow_high, // Channel trips, cleanup differential flow.
   input wire logic [3:0] fw_dp_high, // Channel trips, feedwater line differential pressure.
   input wire logic [3:0] level_nine_high, // Channel trips, water level very high.
   input wire logic run_mode, // Reactor is in Run mode.
   input wire logic man_scram_sw, // Hardwired manual scram switch.
   input wire logic man_scram_odu, // Manual scram from operator display unit.
   input wire logic man_emergency_core_cooling_sw, // Manual core cooling from local logic inputs.
   input wire logic man_emergency_core_cooling_odu, // Manual core cooling from operator display unit.
   input wire logic man_pool_equalize, // Manual suppression pool equalization.
   output logic [2:0] proc_scram_q, // Per-processor scram decision, one link each.
   output logic scram_return_open_q, // Opens solenoid return power switches.
   output logic [1:0] emergency_core_cooling_drv_start_q, // Sealed start of each output driver.
   output logic emergency_core_cooling_actuate_q, // Core cooling actuation, both drivers agree.
   output logic [`DPS_NUM_SRV-1:0] srv_solenoid_q, // Dedicated relief valve solenoids.
   output logic [`DPS_NUM_DPV-1:0] dpv_squib_q, // Depressurization valve squibs.
   output logic [`DPS_NUM_GRAVITY_CORE_COOLING-1:0] gravity_core_cooling_squib_q, // Gravity cooling valve squibs.
   output logic [`DPS_NUM_SLC_LOOP-1:0] slc_squib_q, // Liquid injection squib per loop.
   output logic ic_initiate_q, // Isolation condenser initiation.
   output logic pool_equalize_q, // Suppression pool equalization.
   output logic main_steam_isolation_valves_close_q, // Close steam isolation valves.
   output logic ic_isol_close_q, // Close condenser isolation valves.
   output logic cleanup_isol_close_q, // Close cleanup isolation valves.
   output logic fw_breaker_trip_q, // Trip feedwater pump drive breakers.
   output logic fw_cont_isol_close_q, // Close feedwater containment isolation.
   output logic fw_runback_q, // Feedwater pump runback.
   output logic fw_pump_trip_q // Feedwater pump trip.
);

   localparam int NP = `DPS_NUM_PARAM;
   localparam int NC = `DPS_NUM_CHAN;

   logic rst_meta_q;
   logic rst_n;
   logic [NP*NC-1:0] sens_all;
   logic [NP-1:0] proc_trip [`DPS_NUM_PROC];
   logic [NP-1:0] voted;
   logic [2:0] proc_scram_d;
   logic scram_auto;
   logic scram_d;
   logic emergency_core_cooling_init;
   logic man_emergency_core_cooling;
   logic [1:0] drv_start;
   logic emergency_core_cooling_act;
   logic [`DPS_NUM_DPV_PATH-1:0] dpv_path_q;
   logic [`DPS_NUM_DUAL_PATH-1:0] gravity_core_cooling_path_q;
   logic [`DPS_NUM_DUAL_PATH-1:0] slc_path_q;
   logic main_steam_isolation_valves_close_d;
   logic fw_break_d;
   logic ic_init_d;

   // Reset is released through two flops so every register leaves reset on the same edge.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   assign sens_all = {level_nine_high, fw_dp_high, cleanup_dflow_high, ic_cond_flow_high,
                      ic_steam_flow_high, level_two_low, vessel_press_low, steam_flow_high,
                      level_one_low, main_steam_isolation_valves_closed, pool_temp_high, drywell_press_high,
                      level_three_low, level_eight_high, vessel_press_high};

   genvar k;
   generate
      for (k = 0; k < `DPS_NUM_PROC; k++)
      begin : g_proc
         // Every processor gets the identical set of four channels per parameter.
         vote_processor u_proc
         (
            .clk(clk),
            .rst_n(rst_n),
            .sens(sens_all),
            .trip_q(proc_trip[k])
         );
         assign proc_scram_d[k] = |proc_trip[k][`DPS_P_MAIN_STEAM_ISOLATION_VALVES_CLOSED:0];
      end
      for (k = 0; k < NP; k++)
      begin : g_vote
         assign voted[k] = dps_pkg::two_of_three({proc_trip[2][k], proc_trip[1][k],
                                                  proc_trip[0][k]});
      end
   endgenerate

   // Scram: each processor's own decision is voted 2-of-3 at the final stage.
   assign scram_auto = dps_pkg::two_of_three(proc_scram_d);
   assign scram_d = scram_auto | man_scram_sw | man_scram_odu;

   // Core cooling initiation from voted level one low, or manual request.
   assign emergency_core_cooling_init = voted[`DPS_P_LEVEL_ONE_LOW];
   assign man_emergency_core_cooling = man_emergency_core_cooling_sw | man_emergency_core_cooling_odu;

   generate
      for (k = 0; k < `DPS_NUM_DRV; k++)
      begin : g_drv
         dps_pkg::drv_state_t st_q;
         dps_pkg::drv_state_t st_d;
         logic [31:0] cnt_q;
         logic [31:0] cnt_d;
         logic init_q;

         // Each driver keeps its own copy of the voted signal and its own timer.
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               init_q <= 1'b0;
            else
               init_q <= emergency_core_cooling_init;
         end

         always_comb
         begin
            st_d = st_q;
            cnt_d = cnt_q;
            case (st_q)
               dps_pkg::DRV_IDLE:
               begin
                  cnt_d = 32'h0;
                  if (man_emergency_core_cooling)
                     st_d = dps_pkg::DRV_SEALED;
                  else if (init_q)
                  begin
                     st_d = dps_pkg::DRV_TIMING;
                     cnt_d = 32'h1;
                  end
               end
               dps_pkg::DRV_TIMING:
               begin
                  if (man_emergency_core_cooling)
                     st_d = dps_pkg::DRV_SEALED;
                  else if (!init_q)
                  begin
                     st_d = dps_pkg::DRV_IDLE;
                     cnt_d = 32'h0;
                  end
                  else if (cnt_q >= EMERGENCY_CORE_COOLING_PERSIST_CYC - 32'h1)
                     st_d = dps_pkg::DRV_SEALED;
                  else
                     cnt_d = cnt_q + 32'h1;
               end
               // The seal-in ignores the condition clearing; only reset releases it.
               dps_pkg::DRV_SEALED:
                  st_d = dps_pkg::DRV_SEALED;
               default:
                  st_d = dps_pkg::DRV_IDLE;
            endcase
         end

         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               st_q <= dps_pkg::DRV_IDLE;
               cnt_q <= 32'h0;
            end
            else
            begin
               st_q <= st_d;
               cnt_q <= cnt_d;
            end
         end

         assign drv_start[k] = (st_q == dps_pkg::DRV_SEALED);
      end
   endgenerate

   assign emergency_core_cooling_act = &drv_start;

   // Squib paths are separate flops so a single stuck path cannot fire a valve alone.
   generate
      for (k = 0; k < `DPS_NUM_DPV_PATH; k++)
      begin : g_dpv_path
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               dpv_path_q[k] <= 1'b0;
            else
               dpv_path_q[k] <= emergency_core_cooling_act;
         end
      end
      for (k = 0; k < `DPS_NUM_DUAL_PATH; k++)
      begin : g_dual_path
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               gravity_core_cooling_path_q[k] <= 1'b0;
               slc_path_q[k] <= 1'b0;
            end
            else
            begin
               gravity_core_cooling_path_q[k] <= emergency_core_cooling_act;
               slc_path_q[k] <= emergency_core_cooling_act;
            end
         end
      end
   endgenerate

   // Isolations and feedwater actions from voted parameters; condenser initiation also on core cooling actuation.
   assign main_steam_isolation_valves_close_d = run_mode & (voted[`DPS_P_STEAM_FLOW_HIGH] |
                                     voted[`DPS_P_VESSEL_PRESS_LOW] |
                                     voted[`DPS_P_LEVEL_TWO_LOW]);
   assign fw_break_d = voted[`DPS_P_FW_DP_HIGH] & voted[`DPS_P_DRYWELL_PRESS_HIGH];
   assign ic_init_d = emergency_core_cooling_act | voted[`DPS_P_LEVEL_TWO_LOW] |
                      voted[`DPS_P_MAIN_STEAM_ISOLATION_VALVES_CLOSED];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         proc_scram_q <= 3'h0;
         scram_return_open_q <= 1'b0;
         emergency_core_cooling_drv_start_q <= 2'h0;
         emergency_core_cooling_actuate_q <= 1'b0;
         srv_solenoid_q <= '0;
         dpv_squib_q <= '0;
         gravity_core_cooling_squib_q <= '0;
         slc_squib_q <= '0;
      end
      else
      begin
         proc_scram_q <= proc_scram_d;
         scram_return_open_q <= scram_d;
         emergency_core_cooling_drv_start_q <= drv_start;
         emergency_core_cooling_actuate_q <= emergency_core_cooling_act;
         srv_solenoid_q <= {`DPS_NUM_SRV{emergency_core_cooling_act}};
         dpv_squib_q <= {`DPS_NUM_DPV{&dpv_path_q}};
         gravity_core_cooling_squib_q <= {`DPS_NUM_GRAVITY_CORE_COOLING{&gravity_core_cooling_path_q}};
         slc_squib_q <= {`DPS_NUM_SLC_LOOP{&slc_path_q}};
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ic_initiate_q <= 1'b0;
         pool_equalize_q <= 1'b0;
         main_steam_isolation_valves_close_q <= 1'b0;
         ic_isol_close_q <= 1'b0;
         cleanup_isol_close_q <= 1'b0;
         fw_breaker_trip_q <= 1'b0;
         fw_cont_isol_close_q <= 1'b0;
         fw_runback_q <= 1'b0;
         fw_pump_trip_q <= 1'b0;
      end
      else
      begin
         ic_initiate_q <= ic_init_d;
         pool_equalize_q <= man_pool_equalize;
         main_steam_isolation_valves_close_q <= main_steam_isolation_valves_close_d;
         ic_isol_close_q <= voted[`DPS_P_IC_STEAM_FLOW_HIGH] |
                            voted[`DPS_P_IC_COND_FLOW_HIGH];
         cleanup_isol_close_q <= voted[`DPS_P_CLEANUP_DFLOW_HIGH];
         fw_breaker_trip_q <= fw_break_d;
         fw_cont_isol_close_q <= fw_break_d;
         fw_runback_q <= voted[`DPS_P_LEVEL_EIGHT_HIGH];
         fw_pump_trip_q <= voted[`DPS_P_LEVEL_NINE_HIGH];
      end
   end

endmodule

// File: rtl/dps_map.svh
// Constants for the diverse trip voting logic: trip parameter indices, counts and timing.
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH

`define DPS_CLK_HZ 125000000
`define DPS_EMERGENCY_CORE_COOLING_PERSIST_S 10
`define DPS_EMERGENCY_CORE_COOLING_PERSIST_CYC (`DPS_EMERGENCY_CORE_COOLING_PERSIST_S * `DPS_CLK_HZ)

`define DPS_NUM_CHAN 4
`define DPS_NUM_PROC 3
`define DPS_NUM_DRV 2
`define DPS_NUM_PARAM 15

`define DPS_P_VESSEL_PRESS_HIGH 0
`define DPS_P_LEVEL_EIGHT_HIGH 1
`define DPS_P_LEVEL_THREE_LOW 2
`define DPS_P_DRYWELL_PRESS_HIGH 3
`define DPS_P_POOL_TEMP_HIGH 4
`define DPS_P_MAIN_STEAM_ISOLATION_VALVES_CLOSED 5
`define DPS_P_LEVEL_ONE_LOW 6
`define DPS_P_STEAM_FLOW_HIGH 7
`define DPS_P_VESSEL_PRESS_LOW 8
`define DPS_P_LEVEL_TWO_LOW 9
`define DPS_P_IC_STEAM_FLOW_HIGH 10
`define DPS_P_IC_COND_FLOW_HIGH 11
`define DPS_P_CLEANUP_DFLOW_HIGH 12
`define DPS_P_FW_DP_HIGH 13
`define DPS_P_LEVEL_NINE_HIGH 14

`define DPS_NUM_SRV 10
`define DPS_NUM_DPV 8
`define DPS_NUM_GRAVITY_CORE_COOLING 8
`define DPS_NUM_SLC_LOOP 2
`define DPS_NUM_DPV_PATH 3
`define DPS_NUM_DUAL_PATH 2

`endif

// File: rtl/dps_pkg.sv
// Types and voting functions shared by the diverse trip voting logic.
package dps_pkg;

   typedef enum logic [1:0]
   {
      DRV_IDLE = 2'h0,
      DRV_TIMING = 2'h1,
      DRV_SEALED = 2'h3
   } drv_state_t;

   function automatic logic two_of_four(input logic [3:0] v);
      two_of_four = (v[0] & v[1]) | (v[0] & v[2]) | (v[0] & v[3]) |
                    (v[1] & v[2]) | (v[1] & v[3]) | (v[2] & v[3]);
   endfunction

   function automatic logic two_of_three(input logic [2:0] v);
      two_of_three = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

endpackage

// File: rtl/vote_processor.sv
// One redundant processing channel: samples all sensor channels and forms 2-of-4 coincidence.
`timescale 1ns/1ps
`include "dps_map.svh"

module vote_processor
(
   input wire logic clk, // System clock.
   input wire logic rst_n, // Synchronised reset, active low.
   input wire logic [`DPS_NUM_PARAM*`DPS_NUM_CHAN-1:0] sens, // Channel trips, 4 per parameter.
   output logic [`DPS_NUM_PARAM-1:0] trip_q // Coincidence trip per parameter.
);

   logic [`DPS_NUM_PARAM*`DPS_NUM_CHAN-1:0] samp_q;
   logic [`DPS_NUM_PARAM-1:0] trip_d;

   // All channels are captured in one edge so every decision sees one cycle's inputs.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         samp_q <= '0;
      else
         samp_q <= sens;
   end

   genvar p;
   generate
      for (p = 0; p < `DPS_NUM_PARAM; p++)
      begin : g_par
         assign trip_d[p] = dps_pkg::two_of_four(samp_q[p*`DPS_NUM_CHAN +: `DPS_NUM_CHAN]);
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         trip_q <= '0;
      else
         trip_q <= trip_d;
   end

endmodule
